// ==== design/pwm_temp_out.sv ====
// Summary of operation
// - Nominal 25 degC full period is 116 ms
// - High time fixed, low time carries temperature
// - Mode pin latched at power-up
// - Continuous mode repeats waves without request
// - Rate pin latched once after power-up
// - One-shot: one wave per host request
// - Low pulses under 20 ns ignored
// - Wave starts only after host release
// - First rising edge follows the release
// - Rate pin scales high and low times
// - Both intervals timed by one clock
// - Ratio encoded from 12-bit modulator code
// - Daisy-chain uses nominal rate always
module pwm_temp_out (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire pwm_temp_pkg::level_t MODE_SELECT_PIN_I,
   input wire pwm_temp_pkg::level_t RATE_SELECT_CHAIN_INPUT_I,
   input wire logic [11:0] TEMP_CODE_I,
   input wire logic LINE_I,
   output logic OUT_O,
   output logic OUT_OE_O,
   output logic BUSY_O,
   output pwm_temp_pkg::mode_t MODE_O
);
   pwm_temp_pkg::regs_t r_q;
   pwm_temp_pkg::regs_t r_d;

   // Interval lengths in cycles for the latched rate
   function automatic logic [31:0] th_cycles(input pwm_temp_pkg::level_t lv);
      logic [31:0] v;
      case (lv)
         pwm_temp_pkg::LVL_LOW: begin
            v = 32'(pwm_temp_pkg::TH_QUART_US * pwm_temp_pkg::CYC_PER_US);
         end
         pwm_temp_pkg::LVL_HIGH: begin
            v = 32'(pwm_temp_pkg::TH_DOUBLE_US * pwm_temp_pkg::CYC_PER_US);
         end
         default: begin
            // Floating and the unused code give the nominal high time
            v = 32'(pwm_temp_pkg::TH_NOM_US * pwm_temp_pkg::CYC_PER_US);
         end
      endcase
      return v;
   endfunction

   // Low time scales with the code; code 0x800 gives the 25 degC value
   function automatic logic [31:0] tl_cycles(input pwm_temp_pkg::level_t lv,
                                             input logic [11:0] code);
      logic [63:0] base;
      logic [63:0] prod;
      case (lv)
         pwm_temp_pkg::LVL_FLOAT: begin
            base = 64'(pwm_temp_pkg::TL_NOM_US * pwm_temp_pkg::CYC_PER_US);
         end
         default: begin
            // Low and high rate settings share the quarter low time
            base = 64'(pwm_temp_pkg::TL_QUART_US * pwm_temp_pkg::CYC_PER_US);
         end
      endcase
      // Wide product so the largest code cannot overflow
      prod = (base * {52'h0, code}) / {52'h0, pwm_temp_pkg::CODE_25C};
      return prod[31:0];
   endfunction

   // Strap decode, used only on the first edge after reset
   pwm_temp_pkg::mode_t strap_mode;
   pwm_temp_pkg::level_t strap_rate;
   always_comb begin
      strap_mode = pwm_temp_pkg::MODE_CONT;
      strap_rate = RATE_SELECT_CHAIN_INPUT_I;
      case (MODE_SELECT_PIN_I)
         pwm_temp_pkg::LVL_LOW: begin
            strap_mode = pwm_temp_pkg::MODE_ONESHOT;
         end
         pwm_temp_pkg::LVL_HIGH: begin
            // Chain mode ignores the rate pin
            strap_mode = pwm_temp_pkg::MODE_CHAIN;
            strap_rate = pwm_temp_pkg::LVL_FLOAT;
         end
         default: begin
            // Unused code falls back to free running
            strap_mode = pwm_temp_pkg::MODE_CONT;
         end
      endcase
   end

   always_comb begin
      r_d = r_q;
      // Strap capture once after reset release
      if (!r_q.latched) begin
         r_d.latched = 1'b1;
         r_d.mode = strap_mode;
         r_d.rate = strap_rate;
      end else begin
         case (r_q.state)
            pwm_temp_pkg::ST_IDLE: begin
               r_d.out = 1'b1;
               r_d.busy = 1'b0;
               if (r_q.mode != pwm_temp_pkg::MODE_ONESHOT) begin
                  r_d.state = pwm_temp_pkg::ST_HIGH;
                  r_d.cnt = th_cycles(r_q.rate);
                  r_d.busy = 1'b1;
               end else if (!LINE_I) begin
                  r_d.state = pwm_temp_pkg::ST_REQ;
                  r_d.req_cnt = 8'h01;
               end
            end
            pwm_temp_pkg::ST_REQ: begin
               if (!LINE_I) begin
                  if (r_q.req_cnt != 8'hFF) begin
                     r_d.req_cnt = r_q.req_cnt + 8'h01;
                  end
               end else if (r_q.req_cnt >= 8'(pwm_temp_pkg::REQ_MIN_CYC)) begin
                  // Drive low first so the rising edge follows release
                  r_d.state = pwm_temp_pkg::ST_LOW;
                  r_d.out = 1'b0;
                  r_d.busy = 1'b1;
                  r_d.cnt = 32'h0000_0001;
                  r_d.tl_len = 32'h0000_0000;
               end else begin
                  r_d.state = pwm_temp_pkg::ST_IDLE;
               end
            end
            pwm_temp_pkg::ST_HIGH: begin
               r_d.out = 1'b1;
               if (r_q.cnt <= 32'h0000_0001) begin
                  r_d.state = pwm_temp_pkg::ST_LOW;
                  r_d.out = 1'b0;
                  r_d.cnt = tl_cycles(r_q.rate, TEMP_CODE_I);
                  r_d.tl_len = 32'h0000_0001;
               end else begin
                  r_d.cnt = r_q.cnt - 32'h0000_0001;
               end
            end
            pwm_temp_pkg::ST_LOW: begin
               r_d.out = 1'b0;
               if (r_q.cnt <= 32'h0000_0001) begin
                  if (r_q.tl_len == 32'h0000_0000) begin
                     // One-shot lead-in done, start the wave
                     r_d.state = pwm_temp_pkg::ST_HIGH;
                     r_d.out = 1'b1;
                     r_d.cnt = th_cycles(r_q.rate);
                  end else if (r_q.mode == pwm_temp_pkg::MODE_ONESHOT) begin
                     r_d.state = pwm_temp_pkg::ST_IDLE;
                     r_d.out = 1'b1;
                     r_d.busy = 1'b0;
                  end else begin
                     r_d.state = pwm_temp_pkg::ST_HIGH;
                     r_d.out = 1'b1;
                     r_d.cnt = th_cycles(r_q.rate);
                  end
               end else begin
                  r_d.cnt = r_q.cnt - 32'h0000_0001;
               end
            end
            default: begin
               r_d.state = pwm_temp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Reset leaves the line released and the straps unlatched
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         r_q <= '{state: pwm_temp_pkg::ST_IDLE,
                  mode: pwm_temp_pkg::MODE_CONT,
                  rate: pwm_temp_pkg::LVL_FLOAT,
                  latched: 1'b0,
                  cnt: 32'h0,
                  tl_len: 32'h0,
                  req_cnt: 8'h00,
                  out: 1'b1,
                  busy: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   // One-shot idles released so the host can pull the line low
   // Decoded from the next state so the enable moves with the data
   logic oe_d;
   logic oe_q;
   always_comb begin
      oe_d = 1'b1;
      if (r_d.mode == pwm_temp_pkg::MODE_ONESHOT) begin
         case (r_d.state)
            pwm_temp_pkg::ST_IDLE: begin
               oe_d = 1'b0;
            end
            pwm_temp_pkg::ST_REQ: begin
               // Never fight the host while it holds the line
               oe_d = 1'b0;
            end
            default: begin
               oe_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   assign OUT_O = r_q.out;
   assign OUT_OE_O = oe_q;
   assign BUSY_O = r_q.busy;
   assign MODE_O = r_q.mode;
endmodule

// ==== include/pwm_temp_pkg.sv ====
package pwm_temp_pkg;
   // Three-level pin encodings, as resolved by the pad
   typedef enum logic [1:0] {
      LVL_LOW,
      LVL_FLOAT,
      LVL_HIGH
   } level_t;

   typedef enum logic [1:0] {
      MODE_ONESHOT,
      MODE_CONT,
      MODE_CHAIN
   } mode_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_REQ,
      ST_HIGH,
      ST_LOW
   } state_t;

   localparam int unsigned CLK_HZ = 100_000_000;
   // Times in microseconds at 25 degC
   localparam int unsigned TH_NOM_US = 40_000;
   localparam int unsigned TL_NOM_US = 76_000;
   localparam int unsigned TH_QUART_US = 10_000;
   localparam int unsigned TL_QUART_US = 19_000;
   localparam int unsigned TH_DOUBLE_US = 80_000;
   // Minimum host request pulse, in nanoseconds
   localparam int unsigned REQ_MIN_NS = 20;
   localparam int unsigned REQ_MIN_CYC = (REQ_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   // Modulator code width and value giving the nominal low time at 25 degC
   localparam int unsigned CODE_W = 12;
   localparam logic [11:0] CODE_25C = 12'h800;
   localparam int unsigned CNT_W = 32;

   typedef struct packed {
      state_t state;
      mode_t mode;
      level_t rate;
      logic latched;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] tl_len;
      logic [7:0] req_cnt;
      logic out;
      logic busy;
   } regs_t;
endpackage

// ==== testbench/host_model.sv ====
module host_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [3:0] width_i,
   output logic pull_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_q = 4'h0;
   always_ff @(posedge clk_i) begin
      if (go_i) begin
         left_q <= width_i;
      end else if (left_q != 4'h0) begin
         left_q <= left_q - 4'h1;
      end
   end
   assign pull_o = left_q != 4'h0;
   // Host decode in hundredths of a degree from counts of one clock
   function automatic int temp_c100(input longint th, input longint tl, input logic high_rate);
      longint v;
      v = 64'd42100 - (64'd75100 * th) / tl;
      if (high_rate) begin
         v = 64'd42100 - (64'd93875 * th) / (tl * 64'd10);
      end
      return int'(v);
   endfunction
endmodule

// ==== testbench/pwm_temp_out_sva.sv ====
module pwm_temp_out_sva (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic LINE_I,
   input wire logic OUT_O,
   input wire logic OUT_OE_O,
   input wire logic BUSY_O,
   input wire pwm_temp_pkg::mode_t MODE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic os;
   assign os = MODE_O == pwm_temp_pkg::MODE_ONESHOT;
   mode_hold_a: assert property ($past(RST_N_I) && $past(RST_N_I, 2) |-> $stable(MODE_O))
      else $error("mode moved");
   idle_quiet_a: assert property ((os && !BUSY_O && !OUT_OE_O && LINE_I) [*2] |=> !OUT_OE_O)
      else $error("spurious start");
   short_pulse_a: assert property ((os && !BUSY_O && !OUT_OE_O && LINE_I) ##1 (!LINE_I && !OUT_OE_O)
      ##1 LINE_I |=> !OUT_OE_O [*2])
      else $error("short pulse taken");
   start_after_a: assert property (os && $rose(OUT_OE_O) |-> $past(LINE_I) && !OUT_O)
      else $error("start before release");
   first_rise_a: assert property (os && $rose(OUT_OE_O) |=> OUT_O && OUT_OE_O)
      else $error("no rise");
   req_start_a: assert property ((os && !BUSY_O && !OUT_OE_O && !LINE_I) ##1 !LINE_I ##1 LINE_I
      |=> OUT_OE_O && !OUT_O)
      else $error("request lost");
   cont_drive_a: assert property ($past(RST_N_I) && $past(RST_N_I, 2) && $past(RST_N_I, 3) && !os
      |-> OUT_OE_O)
      else $error("free run stopped");
   high_hold_a: assert property ($rose(OUT_O) && OUT_OE_O |=> $stable(OUT_O) [*8])
      else $error("short high");
   os_c: cover property (os && $rose(OUT_OE_O));
   run_c: cover property (!os && OUT_OE_O);
   rise_c: cover property ($rose(OUT_O) && OUT_OE_O);
endmodule
bind pwm_temp_out pwm_temp_out_sva pwm_temp_out_sva_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .LINE_I(LINE_I), .OUT_O(OUT_O), .OUT_OE_O(OUT_OE_O), .BUSY_O(BUSY_O), .MODE_O(MODE_O));

// ==== testbench/pwm_temperature_output_test.sv ====
module pwm_temperature_output_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      pwm_temp_pkg::level_t pin;
      pwm_temp_pkg::mode_t mode;
      logic drive;
   } row_t;
   row_t rows [3] = '{'{pwm_temp_pkg::LVL_LOW, pwm_temp_pkg::MODE_ONESHOT, 1'b0},
      '{pwm_temp_pkg::LVL_FLOAT, pwm_temp_pkg::MODE_CONT, 1'b1},
      '{pwm_temp_pkg::LVL_HIGH, pwm_temp_pkg::MODE_CHAIN, 1'b1}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   pwm_temp_pkg::level_t mpin = pwm_temp_pkg::LVL_LOW;
   pwm_temp_pkg::level_t rpin = pwm_temp_pkg::LVL_FLOAT;
   logic [11:0] code = 12'h800;
   logic go = 1'b0;
   logic [3:0] width = 4'h2;
   logic pull, line, out, oe, busy;
   pwm_temp_pkg::mode_t mode;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   // Pulled-up line shared with the host
   assign line = !pull && (!oe || out);
   pwm_temp_out pwm_temp_out_i (.CLK_I(clk), .RST_N_I(rst_n), .MODE_SELECT_PIN_I(mpin),
      .RATE_SELECT_CHAIN_INPUT_I(rpin), .TEMP_CODE_I(code), .LINE_I(line), .OUT_O(out),
      .OUT_OE_O(oe), .BUSY_O(busy), .MODE_O(mode));
   host_model host_model_i (.clk_i(clk), .go_i(go), .width_i(width), .pull_o(pull));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic restart(input pwm_temp_pkg::level_t m);
      @(posedge clk);
      rst_n <= 1'b0;
      mpin <= m;
      rpin <= pwm_temp_pkg::LVL_FLOAT;
      tick(8);
      rst_n <= 1'b1;
   endtask
   task automatic pulse(input logic [3:0] w);
      @(posedge clk);
      width <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test;
      end
   end
   initial begin
      tick(4);
      @(negedge clk);
      check(out, 1'b1);
      check(oe, 1'b0);
      check(busy, 1'b0);
      check(mode, pwm_temp_pkg::MODE_CONT);
      foreach (rows[i]) begin
         restart(rows[i].pin);
         tick(4);
         mpin <= rows[(i + 1) % 3].pin;
         rpin <= pwm_temp_pkg::LVL_HIGH;
         tick(4);
         @(negedge clk);
         check(mode, rows[i].mode);
         check(oe, rows[i].drive);
         check(busy, rows[i].drive);
      end
      check(host_model_i.temp_c100(40000, 76000, 1'b0), 32'h0000_0A0E);
      check(host_model_i.temp_c100(10000, 19000, 1'b0), 32'h0000_0A0E);
      check(host_model_i.temp_c100(80000, 19000, 1'b1), 32'h0000_0A0E);
      restart(pwm_temp_pkg::LVL_LOW);
      tick(4);
      pulse(4'h1);
      tick(6);
      @(negedge clk);
      check(oe, 1'b0);
      check(busy, 1'b0);
      pulse(4'h2);
      tick(5);
      @(negedge clk);
      check(oe, 1'b1);
      check(out, 1'b1);
      check(busy, 1'b1);
      tick(5000);
      @(negedge clk);
      check(out, 1'b1);
      stop_test;
   end
endmodule
